/* File: bench/ipi_host_model.sv */
// Host model that issues register reads and writes
`timescale 1ns/1ns
`default_nettype none
module ipi_host_model
   import ipi_pkg::*;
(
   // Clock
   input wire logic                    clk,
   // Register access
   output var ipi_pkg::ipi_reg_req_t   regReq,
   input wire logic [7:0]              rdData,
   input wire logic                    rdValid
);
   initial regReq = '0;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regReq <= '{rdEn: 1'b0, wrEn: 1'b1, addr: a, wrData: d};
      @(posedge clk);
      regReq.wrEn <= 1'b0;
   endtask

   // Answer missing within four cycles leaves unknown data
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      d = 8'hxx;
      @(posedge clk);
      regReq <= '{rdEn: 1'b1, wrEn: 1'b0, addr: a, wrData: 8'h00};
      @(posedge clk);
      regReq.rdEn <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         if (rdValid === 1'b1) begin
            d = rdData;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

/* File: bench/ipi_regs_sva.sv */
// Port checker for the pin function and interrupt registers
`timescale 1ns/1ns
`default_nettype none
module ipi_regs_chk
   import ipi_pkg::*;
(
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  srst,
   // Observed ports
   input wire ipi_pkg::ipi_reg_req_t regReq,
   input wire logic                  rdValid,
   input wire logic                  irqOut,
   input wire logic [3:0]            pinLevelIn,
   input wire logic [3:0]            densityDataIn,
   input wire logic [3:0]            densityValid,
   input wire logic                  mclkIn,
   input wire logic                  mclkValid,
   input wire logic                  daisyValid,
   input wire logic                  daisyChainDataIn
);
   logic [7:0] selShadow_ff;
   logic [2:0] s3;
   logic [2:0] s4;
   logic [3:0] dens;

   assign s3 = selShadow_ff[6:4];
   assign s4 = selShadow_ff[2:0];

   // Copy of the upper selector register
   always_ff @(posedge clk) begin
      if (srst) begin
         selShadow_ff <= 8'h00;
      end else if (regReq.wrEn && regReq.addr == ADDR_PIN_FUNC_UPPER) begin
         selShadow_ff <= regReq.wrData;
      end
   end

   always_comb begin
      dens = 4'h0;
      if (s3[2]) dens[s3[1:0]] = 1'b1;
      if (s4[2]) dens[s4[1:0]] = 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   rd_answer_a: assert property (regReq.rdEn |=> rdValid)
      else $error("read not answered");
   rd_quiet_a: assert property (!regReq.rdEn |=> !rdValid)
      else $error("read valid without read");
   irq_idle_a: assert property ($fell(srst) |-> irqOut)
      else $error("interrupt not idle high after reset");
   mclk_route_a: assert property
      (mclkValid == $past(s3 == 3'h2 || s4 == 3'h2))
      else $error("clock input routing wrong");
   daisy_route_a: assert property
      (daisyValid == $past(s3 == 3'h3 || s4 == 3'h3))
      else $error("daisy input routing wrong");
   density_pair_a: assert property (densityValid == $past(dens))
      else $error("density pair routing wrong");
   mclk_data_a: assert property (mclkValid |->
      mclkIn == $past(s3 == 3'h2 ? pinLevelIn[1] : pinLevelIn[0]))
      else $error("clock input data wrong");
   density_data_a: assert property (densityValid[0] |->
      densityDataIn[0] == $past(s3 == 3'h4 ? pinLevelIn[1] : pinLevelIn[0]))
      else $error("density data wrong");
   daisy_data_a: assert property (daisyValid |->
      daisyChainDataIn == $past(s3 == 3'h3 ? pinLevelIn[1] : pinLevelIn[0]))
      else $error("daisy input data wrong");
endmodule

bind ipi_regs ipi_regs_chk u_chk (
   .clk(clk), .srst(srst), .regReq(regReq), .rdValid(rdValid),
   .irqOut(irqOut), .pinLevelIn(pinLevelIn), .densityDataIn(densityDataIn),
   .densityValid(densityValid), .mclkIn(mclkIn), .mclkValid(mclkValid),
   .daisyValid(daisyValid), .daisyChainDataIn(daisyChainDataIn)
);
`default_nettype wire

/* File: bench/tb_top.sv */
// Testbench for the pin function and interrupt registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ipi_pkg::*;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic [3:0]   pinLevelIn = 4'ha;
   ipi_pin_fn_t  pin1Sel = FN_DISABLED;
   ipi_pin_fn_t  pin2Sel = FN_DISABLED;
   ipi_irq_src_t irqSrc = '0;
   ipi_reg_req_t regReq;
   logic [7:0]   rdData;
   logic         rdValid;
   logic         irqOut;
   logic [7:0]   got;
   logic [7:0]   cnt;
   int           error_cnt = 0;
   int           num_checks = 0;

   always #25 clk = ~clk;

   ipi_host_model u_host (.clk(clk), .regReq(regReq), .rdData(rdData),
      .rdValid(rdValid));

   ipi_regs #(.PULSE_CYC(8), .PERIOD_CYC(16)) u_dut (
      .clk(clk), .srst(srst), .regReq(regReq), .rdData(rdData),
      .rdValid(rdValid), .pinLevelIn(pinLevelIn), .pin1FunctionSel(pin1Sel),
      .pin2FunctionSel(pin2Sel), .irqSrc(irqSrc), .irqOut(irqOut),
      .densityDataIn(), .densityValid(), .mclkIn(), .mclkValid(),
      .daisyChainDataIn(), .daisyValid());

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, got);
      check(got, exp);
   endtask

   task automatic pulse(input logic err);
      @(posedge clk);
      irqSrc <= {err, ~err};
      @(posedge clk);
      irqSrc <= '0;
   endtask

   task automatic lowcnt(input int n);
      cnt = 8'h00;
      repeat (n) begin
         @(posedge clk);
         if (irqOut === 1'b0) cnt++;
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rdchk(ADDR_LEVEL_MONITOR, 8'h00);
      rdchk(ADDR_IRQ_CONFIG, 8'h00);
      rdchk(ADDR_IRQ_MASK_0, 8'hff);
      rdchk(8'h40, 8'h00);
      u_host.wr(ADDR_LEVEL_MONITOR, 8'hff);
      rdchk(ADDR_LEVEL_MONITOR, 8'h00);
      pin1Sel <= FN_PLAIN_IN;
      pin2Sel <= FN_PLAIN_IN;
      u_host.wr(ADDR_PIN_FUNC_UPPER, 8'h99);
      rdchk(ADDR_PIN_FUNC_UPPER, 8'h11);
      rdchk(ADDR_LEVEL_MONITOR, 8'ha0);
      // Every code on both pins, levels toggling
      for (int c = 0; c < 8; c++) begin
         pinLevelIn <= {2'b10, c[0], ~c[0]};
         u_host.wr(ADDR_PIN_FUNC_UPPER, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
         rdchk(ADDR_PIN_FUNC_UPPER, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
      end
      rdchk(ADDR_LEVEL_MONITOR, 8'h80);
      u_host.wr(ADDR_IRQ_CONFIG, 8'hff);
      rdchk(ADDR_IRQ_CONFIG, 8'he4);
      u_host.wr(ADDR_IRQ_CONFIG, 8'h00);
      u_host.wr(ADDR_IRQ_MASK_0, 8'hbf);
      rdchk(ADDR_IRQ_MASK_0, 8'hbf);
      pulse(1'b0);
      repeat (2) @(posedge clk);
      check({7'h0, irqOut}, 8'h00);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h40);
      repeat (3) @(posedge clk);
      check({7'h0, irqOut}, 8'h01);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h00);
      pulse(1'b1);
      repeat (3) @(posedge clk);
      check({7'h0, irqOut}, 8'h01);
      u_host.wr(ADDR_IRQ_CONFIG, 8'h84);
      repeat (2) @(posedge clk);
      check({7'h0, irqOut}, 8'h00);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h00);
      u_host.wr(ADDR_IRQ_CONFIG, 8'h80);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h80);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h00);
      u_host.wr(ADDR_IRQ_CONFIG, 8'h60);
      pulse(1'b0);
      lowcnt(40);
      check(cnt, 8'd8);
      u_host.wr(ADDR_IRQ_CONFIG, 8'h40);
      lowcnt(64);
      check(cnt, 8'd32);
      // Reserved event code keeps the pin idle though an event is pending
      u_host.wr(ADDR_IRQ_CONFIG, 8'h20);
      repeat (4) @(posedge clk);
      check({7'h0, irqOut}, 8'h01);
      // Reset in mid-run brings the mask, config, selector and latched registers back to their reset values
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rdchk(ADDR_IRQ_MASK_0, 8'hff);
      rdchk(ADDR_IRQ_CONFIG, 8'h00);
      rdchk(ADDR_PIN_FUNC_UPPER, 8'h00);
      rdchk(ADDR_IRQ_LATCHED_0, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire

/* File: rtl/ipi_irq_timer.sv */
// Interrupt pulse timer: level, repeating and one-shot output shaping
`timescale 1ns/1ns
`default_nettype none
module ipi_irq_timer #(
   parameter int PULSE_CYC  = ipi_pkg::IRQ_PULSE_CYC,
   parameter int PERIOD_CYC = ipi_pkg::IRQ_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   // Control
   input  wire ipi_pkg::ipi_irq_mode_t mode,
   input  wire logic               pending,
   input  wire logic               trigger,
   // Result
   output logic                    active
);
   import ipi_pkg::*;

   localparam logic [IRQ_CNT_W-1:0] PULSE_LAST  = IRQ_CNT_W'(PULSE_CYC - 1);
   localparam logic [IRQ_CNT_W-1:0] PERIOD_LAST = IRQ_CNT_W'(PERIOD_CYC - 1);
   localparam logic [IRQ_CNT_W-1:0] PULSE_LEN   = IRQ_CNT_W'(PULSE_CYC);

   ipi_tmr_state_t st_ff;
   ipi_tmr_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.lastMode = mode;
      active = 1'b0;
      // RULE15 restart on mode change
      if (mode != st_ff.lastMode) begin
         nxt_st.cnt = '0;
         nxt_st.run = 1'b0;
      end else begin
         case (mode)
            // RULE7 level while pending
            EV_LEVEL: begin
               active = pending;
            end
            // RULE8 repeating 2 ms in 4 ms
            EV_REPEAT: begin
               active = pending && (st_ff.cnt < PULSE_LEN);
               if (!pending) begin
                  nxt_st.cnt = '0;
               end else if (st_ff.cnt == PERIOD_LAST) begin
                  nxt_st.cnt = '0;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 1'b1;
               end
            end
            // RULE9 single pulse per event
            EV_ONESHOT: begin
               active = st_ff.run;
               if (trigger) begin
                  nxt_st.run = 1'b1;
                  nxt_st.cnt = '0;
               end else if (st_ff.run) begin
                  if (st_ff.cnt == PULSE_LAST) begin
                     nxt_st.run = 1'b0;
                     nxt_st.cnt = '0;
                  end else begin
                     nxt_st.cnt = st_ff.cnt + 1'b1;
                  end
               end
            end
            default: begin
               active = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '{cnt: '0, run: 1'b0, lastMode: EV_LEVEL};
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule
`default_nettype wire

/* File: rtl/ipi_regs.sv */
// Pin function, level monitor and interrupt configuration registers
//
// Function
// RULE1: Pin three selector in bits 6-4
// RULE2: Pin four selector in bits 2-0
// RULE3: Codes 4-7 route to channel pairs
// RULE4: Monitor shows plain-input pin levels, bits 7-4
// RULE5: Monitor at 0x2F, resets to zero
// RULE6: Bit 7 sets interrupt output polarity
// RULE7: Event mode 0 asserts while pending
// RULE8: Mode 2 asserts 2 ms every 4 ms
// RULE9: Mode 3 one 2 ms pulse per event
// RULE10: Bit 2 chooses all or unmasked readback
// RULE11: Config at 0x32, resets to zero
// RULE12: Mask at 0x33, resets to FFh
// RULE13: Mask bit 7 clock error, bit 6 lock
// RULE14: Latched flags read-only, clear on read
// RULE15: Pulse timing counted, restarts on mode change
`timescale 1ns/1ns
`default_nettype none
module ipi_regs #(
   parameter int PULSE_CYC  = ipi_pkg::IRQ_PULSE_CYC,
   parameter int PERIOD_CYC = ipi_pkg::IRQ_PERIOD_CYC
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  srst,
   // Register access
   input  wire ipi_pkg::ipi_reg_req_t regReq,
   output logic [7:0]                 rdData,
   output logic                       rdValid,
   // Pins, index 3 is pin one, index 0 is pin four
   input  wire logic [3:0]            pinLevelIn,
   input  wire ipi_pkg::ipi_pin_fn_t  pin1FunctionSel,
   input  wire ipi_pkg::ipi_pin_fn_t  pin2FunctionSel,
   // Interrupt sources
   input  wire ipi_pkg::ipi_irq_src_t irqSrc,
   // Interrupt pin
   output logic                       irqOut,
   // Routed pin data
   output logic [3:0]                 densityDataIn,
   output logic [3:0]                 densityValid,
   output logic                       mclkIn,
   output logic                       mclkValid,
   output logic                       daisyChainDataIn,
   output logic                       daisyValid
);
   import ipi_pkg::*;

   ipi_state_t st_ff;
   ipi_state_t nxt_st;

   logic [1:0] srcEvt;
   logic [1:0] srcMask;
   logic [1:0] unmaskedLatched;
   logic [1:0] shownLatched;
   logic       timerActive;
   logic [3:0] plainIn;
   ipi_pin_fn_t pinSel [4];

   // RULE13 mask bits per source
   assign srcEvt  = {irqSrc.asiClkErr, irqSrc.pllLock};
   assign srcMask = {st_ff.mask[SRC_ASI_ERR_BIT],
                     st_ff.mask[SRC_PLL_LOCK_BIT]};
   assign unmaskedLatched = st_ff.latched & ~srcMask;
   // RULE10 readback view selection
   assign shownLatched = st_ff.readbackSel ? unmaskedLatched : st_ff.latched;

   assign pinSel[0] = st_ff.pin4Sel;
   assign pinSel[1] = st_ff.pin3Sel;
   assign pinSel[2] = pin2FunctionSel;
   assign pinSel[3] = pin1FunctionSel;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gPlain
         assign plainIn[g] = (pinSel[g] == FN_PLAIN_IN);
      end
   endgenerate

   ipi_irq_timer #(
      .PULSE_CYC  (PULSE_CYC),
      .PERIOD_CYC (PERIOD_CYC)
   ) uTimer (
      .clk     (clk),
      .srst    (srst),
      .mode    (st_ff.irqEvent),
      .pending (|unmaskedLatched),
      .trigger (|(srcEvt & ~srcMask)),
      .active  (timerActive)
   );

   always_comb begin
      logic [1:0] clrMask;
      logic [7:0] rd;
      logic [2:0] code;
      int         pair;
      clrMask = 2'b00;
      rd = 8'h00;
      code = 3'b000;
      pair = 0;
      nxt_st = st_ff;

      // Register writes; read-only addresses ignore writes
      if (regReq.wrEn) begin
         case (regReq.addr)
            // RULE1 pin three selector
            // RULE2 pin four selector
            ADDR_PIN_FUNC_UPPER: begin
               nxt_st.pin3Sel =
                  ipi_pin_fn_t'(regReq.wrData[PIN3_SEL_LSB +: 3]);
               nxt_st.pin4Sel =
                  ipi_pin_fn_t'(regReq.wrData[PIN4_SEL_LSB +: 3]);
            end
            // RULE11 configuration fields
            ADDR_IRQ_CONFIG: begin
               nxt_st.irqPol = regReq.wrData[IRQ_POL_BIT];
               nxt_st.irqEvent =
                  ipi_irq_mode_t'(regReq.wrData[IRQ_EVENT_LSB +: 2]);
               nxt_st.readbackSel = regReq.wrData[READBACK_SEL_BIT];
            end
            // RULE12 mask register
            ADDR_IRQ_MASK_0: begin
               nxt_st.mask = regReq.wrData;
            end
            default: begin
               nxt_st.mask = st_ff.mask;
            end
         endcase
      end

      // Read mux; unmapped addresses read zero
      case (regReq.addr)
         ADDR_PIN_FUNC_UPPER: begin
            rd[PIN3_SEL_LSB +: 3] = st_ff.pin3Sel;
            rd[PIN4_SEL_LSB +: 3] = st_ff.pin4Sel;
         end
         // RULE5 monitor register read
         ADDR_LEVEL_MONITOR: begin
            rd[MON_PIN1_BIT -: 4] = st_ff.monitor;
         end
         ADDR_IRQ_CONFIG: begin
            rd[IRQ_POL_BIT] = st_ff.irqPol;
            rd[IRQ_EVENT_LSB +: 2] = st_ff.irqEvent;
            rd[READBACK_SEL_BIT] = st_ff.readbackSel;
         end
         ADDR_IRQ_MASK_0: begin
            rd = st_ff.mask;
         end
         ADDR_IRQ_LATCHED_0: begin
            rd[SRC_ASI_ERR_BIT] = shownLatched[1];
            rd[SRC_PLL_LOCK_BIT] = shownLatched[0];
            // RULE14 clear what was read
            if (regReq.rdEn) begin
               clrMask = shownLatched;
            end
         end
         default: begin
            rd = 8'h00;
         end
      endcase
      nxt_st.rdValid = regReq.rdEn;
      nxt_st.rdData = regReq.rdEn ? rd : st_ff.rdData;

      // RULE14 new event wins over clear
      nxt_st.latched = (st_ff.latched & ~clrMask) | srcEvt;

      // RULE4 monitor tracks plain-input pins
      nxt_st.monitor = pinLevelIn & plainIn;

      // RULE6 polarity of interrupt pin
      nxt_st.irqOut = st_ff.irqPol ? timerActive : ~timerActive;

      // RULE3 route pins three and four by code
      nxt_st.densityValid = 4'h0;
      nxt_st.density = 4'h0;
      nxt_st.mclkValid = 1'b0;
      nxt_st.mclk = 1'b0;
      nxt_st.daisyValid = 1'b0;
      nxt_st.daisy = 1'b0;
      for (int p = 0; p < 2; p++) begin
         code = pinSel[p];
         if (code[2]) begin
            pair = int'(code[1:0]);
            nxt_st.densityValid[pair] = 1'b1;
            nxt_st.density[pair] = pinLevelIn[p];
         end else if (code == FN_MCLK_IN) begin
            nxt_st.mclkValid = 1'b1;
            nxt_st.mclk = pinLevelIn[p];
         end else if (code == FN_DAISY_IN) begin
            nxt_st.daisyValid = 1'b1;
            nxt_st.daisy = pinLevelIn[p];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= '0;
         st_ff.pin3Sel <= ipi_pin_fn_t'(RST_PIN_FUNC_UPPER[PIN3_SEL_LSB +: 3]);
         st_ff.pin4Sel <= ipi_pin_fn_t'(RST_PIN_FUNC_UPPER[PIN4_SEL_LSB +: 3]);
         st_ff.irqPol <= RST_IRQ_CONFIG[IRQ_POL_BIT];
         st_ff.irqEvent <= ipi_irq_mode_t'(RST_IRQ_CONFIG[IRQ_EVENT_LSB +: 2]);
         st_ff.readbackSel <= RST_IRQ_CONFIG[READBACK_SEL_BIT];
         st_ff.mask <= RST_IRQ_MASK_0;
         st_ff.monitor <= RST_LEVEL_MONITOR[MON_PIN1_BIT -: 4];
         // Active-low idle level after reset
         st_ff.irqOut <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdData           = st_ff.rdData;
   assign rdValid          = st_ff.rdValid;
   assign irqOut           = st_ff.irqOut;
   assign densityDataIn    = st_ff.density;
   assign densityValid     = st_ff.densityValid;
   assign mclkIn           = st_ff.mclk;
   assign mclkValid        = st_ff.mclkValid;
   assign daisyChainDataIn = st_ff.daisy;
   assign daisyValid       = st_ff.daisyValid;

endmodule
`default_nettype wire

/* File: shared/ipi_pkg.sv */
// Package: register map, field layout, reset values and timing for ipi block
package ipi_pkg;

   // Register addresses on page 0x00
   localparam logic [7:0] ADDR_PIN_FUNC_UPPER = 8'h2c;
   localparam logic [7:0] ADDR_LEVEL_MONITOR  = 8'h2f;
   localparam logic [7:0] ADDR_IRQ_CONFIG     = 8'h32;
   localparam logic [7:0] ADDR_IRQ_MASK_0     = 8'h33;
   localparam logic [7:0] ADDR_IRQ_LATCHED_0  = 8'h36;

   // Field positions
   localparam int PIN3_SEL_LSB     = 4;
   localparam int PIN4_SEL_LSB     = 0;
   localparam int MON_PIN1_BIT     = 7;
   localparam int IRQ_POL_BIT      = 7;
   localparam int IRQ_EVENT_LSB    = 5;
   localparam int READBACK_SEL_BIT = 2;
   localparam int SRC_ASI_ERR_BIT  = 7;
   localparam int SRC_PLL_LOCK_BIT = 6;

   // Reset values
   localparam logic [7:0] RST_PIN_FUNC_UPPER = 8'h00;
   localparam logic [7:0] RST_LEVEL_MONITOR  = 8'h00;
   localparam logic [7:0] RST_IRQ_CONFIG     = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK_0     = 8'hff;

   // Pin function codes
   typedef enum logic [2:0] {
      FN_DISABLED   = 3'b000,
      FN_PLAIN_IN   = 3'b001,
      FN_MCLK_IN    = 3'b010,
      FN_DAISY_IN   = 3'b011,
      FN_DENSITY_A  = 3'b100,
      FN_DENSITY_B  = 3'b101,
      FN_DENSITY_C  = 3'b110,
      FN_DENSITY_D  = 3'b111
   } ipi_pin_fn_t;

   // Interrupt event modes
   typedef enum logic [1:0] {
      EV_LEVEL    = 2'b00,
      EV_RESERVED = 2'b01,
      EV_REPEAT   = 2'b10,
      EV_ONESHOT  = 2'b11
   } ipi_irq_mode_t;

   // Timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int IRQ_PULSE_US  = 2000;
   localparam int IRQ_PERIOD_US = 4000;
   localparam int IRQ_PULSE_CYC  = (CLK_HZ / 1_000_000) * IRQ_PULSE_US;
   localparam int IRQ_PERIOD_CYC = (CLK_HZ / 1_000_000) * IRQ_PERIOD_US;
   localparam int IRQ_CNT_W      = 17;

   // Register access request
   typedef struct packed {
      logic       rdEn;
      logic       wrEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } ipi_reg_req_t;

   // Interrupt source events, one-cycle pulses
   typedef struct packed {
      logic asiClkErr;
      logic pllLock;
   } ipi_irq_src_t;

   // Timer state
   typedef struct packed {
      logic [IRQ_CNT_W-1:0] cnt;
      logic                 run;
      ipi_irq_mode_t        lastMode;
   } ipi_tmr_state_t;

   // Register block state
   typedef struct packed {
      ipi_pin_fn_t   pin3Sel;
      ipi_pin_fn_t   pin4Sel;
      logic          irqPol;
      ipi_irq_mode_t irqEvent;
      logic          readbackSel;
      logic [7:0]    mask;
      logic [1:0]    latched;
      logic [3:0]    monitor;
      logic [7:0]    rdData;
      logic          rdValid;
      logic          irqOut;
      logic [3:0]    density;
      logic [3:0]    densityValid;
      logic          mclk;
      logic          mclkValid;
      logic          daisy;
      logic          daisyValid;
   } ipi_state_t;

endpackage
